// File: pkg/bcs_pkg.sv
package bcs_pkg;

    localparam int CLK_HZ         = 40_000_000;
    localparam int EN_LOW_US      = 50;
    localparam int EN_LOW_CYC_I   = (EN_LOW_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [11:0] EN_LOW_CYC = 12'(EN_LOW_CYC_I);
    localparam int HICCUP_MS      = 100;
    localparam int HICCUP_CYC_DEF = HICCUP_MS * (CLK_HZ / 1000);
    localparam int DEAD_CYC_DEF   = 1;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_VSET     = 8'h10;

    // converter_config_reg fields
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_DSEL = 1;
    localparam int CTRL_OC   = 2;
    localparam int CTRL_FSEL = 4;
    // status fields
    localparam int STS_SEQ = 0;
    localparam int STS_PH  = 8;
    localparam int STS_BYP = 13;
    localparam int STS_PWM = 14;
    localparam int STS_REF = 16;
    // target and ramp fields
    localparam int VSET_TGT  = 0;
    localparam int VSET_RAMP = 8;
    // interrupt bits
    localparam int IRQ_OC    = 0;
    localparam int IRQ_THERM = 1;
    localparam int IRQ_PGOOD = 2;
    localparam int IRQ_ENOFF = 3;
    localparam int IRQ_W     = 4;

    localparam logic       RUN_RST   = 1'b1;
    localparam logic [1:0] OC_HICCUP = 2'h0;
    localparam logic [1:0] OC_LATCH  = 2'h1;
    localparam logic [1:0] OC_LIMIT  = 2'h2;
    localparam logic [1:0] FSEL_AUTO = 2'h0;
    localparam logic [1:0] FSEL_PWM  = 2'h2;

    typedef enum logic [7:0]
    {
        SEQ_OFF   = 8'h01,
        SEQ_INIT  = 8'h02,
        SEQ_OTP   = 8'h04,
        SEQ_SOFT  = 8'h08,
        SEQ_REG   = 8'h10,
        SEQ_HIC   = 8'h20,
        SEQ_LATCH = 8'h40,
        SEQ_THERM = 8'h80
    } bcs_seq_t;

    typedef enum logic [4:0]
    {
        PH_IDLE = 5'h01,
        PH_HS   = 5'h02,
        PH_DT1  = 5'h04,
        PH_LS   = 5'h08,
        PH_DT2  = 5'h10
    } bcs_ph_t;

    typedef struct packed
    {
        logic en_pin;
        logic supply_ok;
        logic ilim_hit;
        logic ipk_hi;
        logic ivly_lo;
        logic therm_trip;
        logic therm_cool;
        logic vin_near;
        logic load_heavy;
        logic pfm_wake;
    } bcs_ana_t;

    localparam int ANA_W = $bits(bcs_ana_t);

endpackage

// File: rtl/bcs_sync3.sv
`timescale 1ns/1ps
module bcs_sync3
    import bcs_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bcs_sync_st_t;

    bcs_sync_st_t st_ff;
    bcs_sync_st_t nxt_st;

    if (W < 1)
    begin : g_chk
        $error("bcs_sync3: width must be at least one");
    end

    // stage one feeds stage two only; a change counts once two and three agree
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q  = (st_ff.s2 & st_ff.s3) | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;
endmodule

// File: rtl/bcs_top.sv
`timescale 1ns/1ps
module bcs_top
    import bcs_pkg::*;
#(
    parameter int HICCUP_CYC = HICCUP_CYC_DEF,
    parameter int DEAD_CYC   = DEAD_CYC_DEF,
    parameter bit BYPASS_EN  = 1'b1
)
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire bcs_ana_t    ana,
    input  wire logic        otp_done,
    input  wire logic [7:0]  otp_target,
    input  wire logic [7:0]  otp_ramp,
    output logic             otp_rd,
    output logic             hs_on,
    output logic             ls_on,
    output logic             bypass_on,
    output logic             discharge_on,
    output logic             pwm_mode,
    output logic             power_down,
    output logic      [7:0]  ref_code,
    output logic             irq
);
    typedef struct packed
    {
        bcs_seq_t          seq;
        bcs_ph_t           ph;
        logic              run;
        logic              dsel;
        logic [1:0]        ocsel;
        logic [1:0]        fsel;
        logic [7:0]        target;
        logic [7:0]        ramp;
        logic [IRQ_W-1:0]  irq_st;
        logic [IRQ_W-1:0]  irq_mask;
        logic [11:0]       en_cnt;
        logic [31:0]       hic_cnt;
        logic [7:0]        ramp_cnt;
        logic [7:0]        dt_cnt;
        logic [7:0]        ref_v;
        logic              hs;
        logic              ls;
        logic              byp;
        logic              bleed;
        logic              pwm;
        logic              pdn;
        logic              otp_rd;
        logic              irq;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } bcs_st_t;

    bcs_st_t          st_ff;
    bcs_st_t          nxt_st;
    bcs_ana_t         a;
    logic             en_off;
    logic             power_ok;
    logic             active;
    logic             byp_sel;
    logic             pwm_want;
    logic             wr_done;
    logic             hit;
    logic [31:0]      rd;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] w1c;

    if (HICCUP_CYC < 2 || DEAD_CYC < 1 || DEAD_CYC > 255)
    begin : g_chk
        $error("bcs_top: hiccup or dead time count out of range");
    end

    bcs_sync3 #(
        .W (ANA_W)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d      (ana),
        .q      (a)
    );

    always_comb
    begin
        nxt_st   = st_ff;
        evt      = '0;
        w1c      = '0;
        rd       = '0;
        hit      = 1'b1;
        // enable-low qualification, restarted by any high sample
        if (a.en_pin)
        begin
            nxt_st.en_cnt = '0;
        end
        else if (st_ff.en_cnt != EN_LOW_CYC)
        begin
            nxt_st.en_cnt = 12'(st_ff.en_cnt + 12'h001);
        end
        en_off   = (st_ff.en_cnt == EN_LOW_CYC);
        power_ok = a.supply_ok && !en_off;
        active   = (st_ff.seq == SEQ_SOFT) || (st_ff.seq == SEQ_REG);
        byp_sel  = BYPASS_EN && a.vin_near;
        pwm_want = (st_ff.fsel == FSEL_PWM) || a.load_heavy;

        // register read mux
        case (paddr)
            OFS_CTRL:
            begin
                rd[CTRL_RUN]       = st_ff.run;
                rd[CTRL_DSEL]      = st_ff.dsel;
                rd[CTRL_OC +: 2]   = st_ff.ocsel;
                rd[CTRL_FSEL +: 2] = st_ff.fsel;
            end
            OFS_STATUS:
            begin
                rd[STS_SEQ +: 8] = st_ff.seq;
                rd[STS_PH +: 5]  = st_ff.ph;
                rd[STS_BYP]      = st_ff.byp;
                rd[STS_PWM]      = st_ff.pwm;
                rd[STS_REF +: 8] = st_ff.ref_v;
            end
            OFS_IRQ_STAT: rd[IRQ_W-1:0] = st_ff.irq_st;
            OFS_IRQ_MASK: rd[IRQ_W-1:0] = st_ff.irq_mask;
            OFS_VSET:
            begin
                rd[VSET_TGT +: 8]  = st_ff.target;
                rd[VSET_RAMP +: 8] = st_ff.ramp;
            end
            default: hit = 1'b0;
        endcase

        // one wait state: answer loaded in the first access cycle
        nxt_st.pready = psel && penable && !st_ff.pready;
        if (psel && penable && !st_ff.pready)
        begin
            nxt_st.prdata  = pwrite ? 32'h0000_0000 : rd;
            nxt_st.pslverr = !hit;
        end
        wr_done = psel && penable && st_ff.pready && pwrite;
        if (wr_done)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    nxt_st.run   = pwdata[CTRL_RUN];
                    nxt_st.dsel  = pwdata[CTRL_DSEL];
                    nxt_st.ocsel = pwdata[CTRL_OC +: 2];
                    nxt_st.fsel  = pwdata[CTRL_FSEL +: 2];
                end
                OFS_IRQ_STAT: w1c = pwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: nxt_st.irq_mask = pwdata[IRQ_W-1:0];
                OFS_VSET:
                begin
                    nxt_st.target = pwdata[VSET_TGT +: 8];
                    nxt_st.ramp   = pwdata[VSET_RAMP +: 8];
                end
                default: nxt_st.run = st_ff.run;
            endcase
        end

        // power sequencer
        if (!power_ok)
        begin
            nxt_st.seq    = SEQ_OFF;
            nxt_st.otp_rd = 1'b0;
            evt[IRQ_ENOFF] = en_off && (st_ff.seq != SEQ_OFF);
        end
        else if (active && a.therm_trip)
        begin
            nxt_st.seq      = SEQ_THERM;
            evt[IRQ_THERM]  = 1'b1;
        end
        else if (active && a.ilim_hit && !byp_sel)
        begin
            evt[IRQ_OC] = 1'b1;
            case (st_ff.ocsel)
                OC_LATCH: nxt_st.seq = SEQ_LATCH;
                OC_LIMIT: nxt_st.seq = st_ff.seq;
                default:
                begin
                    nxt_st.seq     = SEQ_HIC;
                    nxt_st.hic_cnt = '0;
                end
            endcase
        end
        else
        begin
            case (st_ff.seq)
                SEQ_OFF:
                begin
                    if (st_ff.run)
                    begin
                        nxt_st.seq = SEQ_INIT;
                    end
                end
                SEQ_INIT:
                begin
                    nxt_st.seq    = SEQ_OTP;
                    nxt_st.otp_rd = 1'b1;
                end
                SEQ_OTP:
                begin
                    if (otp_done)
                    begin
                        nxt_st.seq    = SEQ_SOFT;
                        nxt_st.otp_rd = 1'b0;
                        nxt_st.target = otp_target;
                        nxt_st.ramp   = otp_ramp;
                        nxt_st.ref_v  = '0;
                    end
                end
                SEQ_SOFT:
                begin
                    if (!st_ff.run)
                    begin
                        nxt_st.seq = SEQ_OFF;
                    end
                    else if (st_ff.ref_v >= st_ff.target)
                    begin
                        nxt_st.seq      = SEQ_REG;
                        nxt_st.ref_v    = st_ff.target;
                        evt[IRQ_PGOOD]  = 1'b1;
                    end
                    else if (st_ff.ramp_cnt >= st_ff.ramp)
                    begin
                        nxt_st.ramp_cnt = '0;
                        nxt_st.ref_v    = 8'(st_ff.ref_v + 8'h01);
                    end
                    else
                    begin
                        nxt_st.ramp_cnt = 8'(st_ff.ramp_cnt + 8'h01);
                    end
                end
                SEQ_REG:
                begin
                    nxt_st.ref_v = st_ff.target;
                    if (!st_ff.run)
                    begin
                        nxt_st.seq = SEQ_OFF;
                    end
                end
                SEQ_HIC:
                begin
                    if (st_ff.hic_cnt == 32'(HICCUP_CYC - 1))
                    begin
                        nxt_st.seq   = SEQ_SOFT;
                        nxt_st.ref_v = '0;
                    end
                    else
                    begin
                        nxt_st.hic_cnt = st_ff.hic_cnt + 32'h0000_0001;
                    end
                end
                SEQ_LATCH:
                begin
                    if (!st_ff.run)
                    begin
                        nxt_st.seq = SEQ_OFF;
                    end
                end
                SEQ_THERM:
                begin
                    if (a.therm_cool)
                    begin
                        nxt_st.seq   = SEQ_SOFT;
                        nxt_st.ref_v = '0;
                    end
                end
                default: nxt_st.seq = SEQ_OFF;
            endcase
        end
        if (nxt_st.seq != SEQ_SOFT)
        begin
            nxt_st.ramp_cnt = '0;
        end

        // switch phase sequence; peak limit also ends the high phase
        if (!active || byp_sel || nxt_st.seq != st_ff.seq)
        begin
            nxt_st.ph = PH_IDLE;
        end
        else
        begin
            case (st_ff.ph)
                PH_IDLE:
                begin
                    if (pwm_want || a.pfm_wake)
                    begin
                        nxt_st.ph = PH_HS;
                    end
                end
                PH_HS:
                begin
                    if (a.ipk_hi || a.ilim_hit)
                    begin
                        nxt_st.ph     = PH_DT1;
                        nxt_st.dt_cnt = '0;
                    end
                end
                PH_DT1:
                begin
                    if (st_ff.dt_cnt == 8'(DEAD_CYC - 1))
                    begin
                        nxt_st.ph = PH_LS;
                    end
                    else
                    begin
                        nxt_st.dt_cnt = 8'(st_ff.dt_cnt + 8'h01);
                    end
                end
                PH_LS:
                begin
                    if (a.ivly_lo)
                    begin
                        nxt_st.ph     = PH_DT2;
                        nxt_st.dt_cnt = '0;
                    end
                end
                PH_DT2:
                begin
                    if (st_ff.dt_cnt == 8'(DEAD_CYC - 1))
                    begin
                        nxt_st.ph = pwm_want ? PH_HS : PH_IDLE;
                    end
                    else
                    begin
                        nxt_st.dt_cnt = 8'(st_ff.dt_cnt + 8'h01);
                    end
                end
                default: nxt_st.ph = PH_IDLE;
            endcase
        end
        nxt_st.hs    = (nxt_st.ph == PH_HS);
        nxt_st.ls    = (nxt_st.ph == PH_LS);
        nxt_st.byp   = power_ok && active && byp_sel;
        nxt_st.pwm   = pwm_want;
        nxt_st.pdn   = !power_ok;
        nxt_st.bleed = (st_ff.seq == SEQ_OFF) && !st_ff.run
                       && st_ff.dsel && a.en_pin && a.supply_ok;
        // a new event beats a clear in the same cycle
        nxt_st.irq_st = (st_ff.irq_st & ~w1c) | evt;
        nxt_st.irq    = |(st_ff.irq_st & st_ff.irq_mask);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff      <= '0;
            st_ff.seq  <= SEQ_OFF;
            st_ff.ph   <= PH_IDLE;
            st_ff.run  <= RUN_RST;
            st_ff.fsel <= FSEL_AUTO;
            st_ff.pdn  <= 1'b1;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata       = st_ff.prdata;
    assign pready       = st_ff.pready;
    assign pslverr      = st_ff.pslverr;
    assign otp_rd       = st_ff.otp_rd;
    assign hs_on        = st_ff.hs;
    assign ls_on        = st_ff.ls;
    assign bypass_on    = st_ff.byp;
    assign discharge_on = st_ff.bleed;
    assign pwm_mode     = st_ff.pwm;
    assign power_down   = st_ff.pdn;
    assign ref_code     = st_ff.ref_v;
    assign irq          = st_ff.irq;

    // a software stop is a legal way out of regulation, so run must be set
    en_qualify_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !en_off && a.supply_ok && st_ff.seq == SEQ_REG && st_ff.run
        |=> st_ff.seq != SEQ_OFF)
        else $error("disabled before enable low time elapsed");
    power_down_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && en_off |=> st_ff.pdn && !st_ff.hs && !st_ff.ls && !st_ff.byp)
        else $error("switching while powered down");
    discharge_on_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && st_ff.seq == SEQ_OFF && !st_ff.run && st_ff.dsel
        && a.en_pin && a.supply_ok |=> st_ff.bleed)
        else $error("discharge path not connected");
    otp_then_ramp_a: assert property (@(posedge clk)
        disable iff (!arst_n)
        ce && power_ok && !active && st_ff.seq == SEQ_OTP && otp_done
        |=> st_ff.seq == SEQ_SOFT && st_ff.ref_v == 8'h00 && !st_ff.otp_rd)
        else $error("soft start did not follow OTP read");
    hiccup_time_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && power_ok && st_ff.seq == SEQ_HIC
        && st_ff.hic_cnt == 32'(HICCUP_CYC - 1)
        |=> st_ff.seq == SEQ_SOFT && st_ff.ref_v == 8'h00)
        else $error("hiccup off time wrong");
    latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && power_ok && st_ff.seq == SEQ_LATCH && st_ff.run
        |=> st_ff.seq == SEQ_LATCH)
        else $error("latched shutdown released");
    limit_stay_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && power_ok && st_ff.seq == SEQ_REG && st_ff.run && a.ilim_hit
        && !a.therm_trip && !byp_sel && st_ff.ocsel == OC_LIMIT
        |=> st_ff.seq == SEQ_REG && !($past(st_ff.hs) && st_ff.hs))
        else $error("current limit did not hold regulation");
    thermal_restart_a: assert property (@(posedge clk)
        disable iff (!arst_n)
        ce && power_ok && st_ff.seq == SEQ_THERM && a.therm_cool
        |=> st_ff.seq == SEQ_SOFT && st_ff.ref_v == 8'h00)
        else $error("no soft start after thermal recovery");
    dead_time_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && ($rose(st_ff.hs) || $rose(st_ff.ls))
        |-> !$past(st_ff.hs) && !$past(st_ff.ls))
        else $error("switches overlap or no dead time");
    forced_pwm_a: assert property (@(posedge clk) disable iff (!arst_n)
        ce && st_ff.fsel == FSEL_PWM |=> st_ff.pwm)
        else $error("forced PWM select ignored");
endmodule

// File: verif/bcs_stage_model.sv
`timescale 1ns/1ps
module bcs_stage_model
    import bcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       otp_rd,
    input  wire logic       hs_on,
    input  wire logic       ls_on,
    output logic            otp_done,
    output logic      [7:0] otp_target,
    output logic      [7:0] otp_ramp,
    output logic            ipk_hi,
    output logic            ivly_lo
);
    logic [3:0] cnt_ff = 4'h0;

    always_ff @(posedge clk)
    begin
        cnt_ff <= (otp_rd || hs_on || ls_on) ? cnt_ff + 4'h1 : 4'h0;
    end

    // memory answers slowly; data is garbage until done
    assign otp_done   = otp_rd && cnt_ff >= 4'h4;
    assign otp_target = otp_done ? 8'h06 : {cnt_ff, ~cnt_ff};
    assign otp_ramp   = otp_done ? 8'h00 : {~cnt_ff, cnt_ff};
    // inductor current reaches a threshold a few cycles into a phase
    assign ipk_hi     = hs_on && cnt_ff >= 4'h3;
    assign ivly_lo    = ls_on && cnt_ff >= 4'h3;
endmodule

// File: verif/tb_buck_control_sequencer.sv
`timescale 1ns/1ps
module tb_buck_control_sequencer
    import bcs_pkg::*;
;
    logic        clk, arst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic        err, otp_done, otp_rd, pk, vl, hs_on, ls_on, bypass_on;
    logic        discharge_on, pwm_mode, power_down, irq;
    logic [7:0]  paddr, otp_target, otp_ramp, ref_code;
    logic [31:0] pwdata, prdata, rd;
    bcs_ana_t    ctl, ana;
    int          bad_count, cmp_count, hs_n, ls_n, both_n;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always_comb
    begin
        ana         = ctl;
        ana.ipk_hi  = pk;
        ana.ivly_lo = vl;
    end

    bcs_top #(.HICCUP_CYC(20)) u_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ana(ana), .otp_done(otp_done),
        .otp_target(otp_target), .otp_ramp(otp_ramp), .otp_rd(otp_rd),
        .hs_on(hs_on), .ls_on(ls_on), .bypass_on(bypass_on),
        .discharge_on(discharge_on), .pwm_mode(pwm_mode),
        .power_down(power_down), .ref_code(ref_code), .irq(irq));

    bcs_stage_model u_stage (.clk(clk), .otp_rd(otp_rd), .hs_on(hs_on),
        .ls_on(ls_on), .otp_done(otp_done), .otp_target(otp_target),
        .otp_ramp(otp_ramp), .ipk_hi(pk), .ivly_lo(vl));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            $display("ERROR pready expected 1 seen %b", pready);
            bad_count++;
            tally_and_finish();
        end
    endtask

    // polls status; a state never reached counts as a mismatch
    task automatic wait_seq(input logic [7:0] s);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[7:0] !== s && n < 400);
        chk("seq", {24'h00_0000, s}, {24'h00_0000, rd[7:0]});
    endtask

    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ctl = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        chk("power_down", 32'h1, {31'h0, power_down});
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0001, rd);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
        ctl.en_pin <= 1'b1;
        ctl.supply_ok <= 1'b1;
        wait_seq(SEQ_REG);
        chk("ref", 32'h0000_0006, {24'h00_0000, rd[23:16]});
        apb(1'b0, OFS_VSET, 32'h0000_0000);
        chk("vset", 32'h0000_0006, rd);
        chk("power_down", 32'h0, {31'h0, power_down});
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_IRQ_STAT, 32'h0000_0004);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_CTRL, 32'h0000_0021);
        repeat (6) @(posedge clk);
        chk("pwm_mode", 32'h1, {31'h0, pwm_mode});
        hs_n = 0;
        ls_n = 0;
        both_n = 0;
        repeat (80)
        begin
            @(posedge clk);
            hs_n += int'(hs_on === 1'b1);
            ls_n += int'(ls_on === 1'b1);
            both_n += int'(hs_on === 1'b1 && ls_on === 1'b1);
        end
        chk("hs seen", 32'h1, 32'(hs_n > 0));
        chk("ls seen", 32'h1, 32'(ls_n > 0));
        chk("overlap", 32'h0, 32'(both_n));
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (6) @(posedge clk);
        chk("pwm_mode", 32'h0, {31'h0, pwm_mode});
        ctl.load_heavy <= 1'b1;
        repeat (8) @(posedge clk);
        chk("pwm_mode", 32'h1, {31'h0, pwm_mode});
        ctl.load_heavy <= 1'b0;
        ctl.ilim_hit <= 1'b1;
        wait_seq(SEQ_HIC);
        ctl.ilim_hit <= 1'b0;
        wait_seq(SEQ_REG);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk("oc flag", 32'h1, {31'h0, rd[IRQ_OC]});
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        ctl.ilim_hit <= 1'b1;
        wait_seq(SEQ_LATCH);
        ctl.ilim_hit <= 1'b0;
        repeat (60) @(posedge clk);
        wait_seq(SEQ_LATCH);
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        wait_seq(SEQ_REG);
        apb(1'b1, OFS_CTRL, 32'h0000_0029);
        ctl.ilim_hit <= 1'b1;
        hs_n = 0;
        repeat (60)
        begin
            @(posedge clk);
            hs_n += int'(hs_on === 1'b1);
        end
        chk("hs under limit", 32'h1, 32'(hs_n > 0));
        wait_seq(SEQ_REG);
        ctl.ilim_hit <= 1'b0;
        ctl.therm_trip <= 1'b1;
        wait_seq(SEQ_THERM);
        chk("hs_on", 32'h0, {31'h0, hs_on});
        ctl.therm_trip <= 1'b0;
        ctl.therm_cool <= 1'b1;
        wait_seq(SEQ_REG);
        chk("ref_code", 32'h6, {24'h00_0000, ref_code});
        ctl.therm_cool <= 1'b0;
        ctl.vin_near <= 1'b1;
        repeat (8) @(posedge clk);
        chk("bypass_on", 32'h1, {31'h0, bypass_on});
        ctl.vin_near <= 1'b0;
        repeat (8) @(posedge clk);
        chk("bypass_on", 32'h0, {31'h0, bypass_on});
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        repeat (6) @(posedge clk);
        chk("discharge_on", 32'h1, {31'h0, discharge_on});
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_seq(SEQ_REG);
        ctl.en_pin <= 1'b0;
        repeat (EN_LOW_CYC_I - 500) @(posedge clk);
        chk("power_down", 32'h0, {31'h0, power_down});
        ctl.en_pin <= 1'b1;
        repeat (20) @(posedge clk);
        ctl.en_pin <= 1'b0;
        repeat (EN_LOW_CYC_I + 100) @(posedge clk);
        chk("power_down", 32'h1, {31'h0, power_down});
        apb(1'b1, OFS_CTRL, 32'h0000_002E);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_002E, rd);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        chk("power_down", 32'h1, {31'h0, power_down});
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0001, rd);
        tally_and_finish();
    end
endmodule
